// File: src/quad_shift_register.sv
`timescale 1ns/1ns

module shift_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PTR_WIDTH = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int COUNT_WIDTH = $clog2(DEPTH + 1);
    localparam logic [COUNT_WIDTH-1:0] COUNT_FULL = COUNT_WIDTH'(DEPTH);
    localparam logic [PTR_WIDTH-1:0] PTR_LAST = PTR_WIDTH'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_WIDTH-1:0] wr_ptr;
    logic [PTR_WIDTH-1:0] rd_ptr;
    logic [COUNT_WIDTH-1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != COUNT_FULL);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    function automatic logic [PTR_WIDTH-1:0] ptr_step(input logic [PTR_WIDTH-1:0] ptr);
        ptr_step = (ptr == PTR_LAST) ? '0 : ptr + 1'b1;
    endfunction : ptr_step

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_step(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= ptr_step(rd_ptr);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

    fifo_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        count <= COUNT_FULL) else $error("fifo count above depth");

endmodule : shift_fifo

module quad_shift_register
    import shift_pkg::*;
#(
    parameter int CHANNELS = CHANNEL_COUNT,
    parameter int STAGES = STAGE_COUNT,
    parameter int DEPTH = FIFO_DEPTH
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Pins from the driving logic
    input wire logic shift_clock,
    input wire logic [CHANNEL_COUNT-1:0] data_in,
    input wire logic [CHANNEL_COUNT-1:0] recirc_select,
    // Local drain stall
    input wire logic shift_hold,
    // Channel outputs and status
    output logic [CHANNEL_COUNT-1:0] data_out,
    output logic sample_ready,
    output logic sample_lost
);
    pin_sample_type sync1;
    pin_sample_type sync2;
    pin_sample_type sync3;
    logic clock_level;
    logic clock_fall;
    shift_word_type fall_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WORD_WIDTH-1:0] fifo_out_bits;
    shift_word_type pop_word;
    logic pop;
    logic [STAGE_COUNT-1:0] stage [CHANNEL_COUNT];

    // Three-stage pin synchroniser for clock, selects and data together
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1 <= PIN_RESET;
            sync2 <= PIN_RESET;
            sync3 <= PIN_RESET;
        end else begin
            sync1 <= '{shift_clock, recirc_select, data_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Clock level counts only once the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clock_level <= PIN_RESET.shift_clock;
        end else if (sync2.shift_clock == sync3.shift_clock) begin
            clock_level <= sync3.shift_clock;
        end
    end

    assign clock_fall = clock_level && !sync3.shift_clock
        && (sync2.shift_clock == sync3.shift_clock);
    assign fall_word = '{sync3.recirc_select, sync3.data_in};

    shift_fifo #(
        .WIDTH(WORD_WIDTH),
        .DEPTH(DEPTH)
    ) sample_buffer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(clock_fall),
        .in_data(fall_word),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_bits),
        .out_ready(!shift_hold)
    );

    assign pop_word = shift_word_type'(fifo_out_bits);
    assign pop = fifo_out_valid && !shift_hold;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sample_ready <= 1'b0;
        end else begin
            sample_ready <= fifo_in_ready;
        end
    end

    // Sticky: an edge that finds the buffer full is dropped
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sample_lost <= 1'b0;
        end else if (clock_fall && !fifo_in_ready) begin
            sample_lost <= 1'b1;
        end
    end

    function automatic logic first_stage_bit(input logic recirc, input logic din,
                                             input logic tail);
        first_stage_bit = recirc ? tail : din;
    endfunction : first_stage_bit

    generate
        for (genvar c = 0; c < CHANNEL_COUNT; c++) begin : g_channel
            // Contents change only when a buffered edge is popped
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    stage[c] <= STAGE_RESET;
                end else if (pop) begin
                    stage[c] <= {stage[c][STAGE_COUNT-2:0], first_stage_bit(
                        pop_word.recirc_select[c], pop_word.data_in[c],
                        stage[c][STAGE_COUNT-1])};
                end
            end
            assign data_out[c] = stage[c][STAGE_COUNT-1];
        end
    endgenerate

    load_input_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pop && !pop_word.recirc_select[0] |=> stage[0][0] == $past(pop_word.data_in[0]))
        else $error("first stage missed the data input");

    recirculate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pop && pop_word.recirc_select[1] |=> stage[1][0] == $past(data_out[1]))
        else $error("first stage missed the recirculated bit");

    stage_shift_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pop |=> stage[2][STAGE_COUNT-1] == $past(stage[2][STAGE_COUNT-2]))
        else $error("channel did not advance one stage");

    static_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !pop |=> $stable(stage[3]) && $stable(data_out))
        else $error("contents changed without an edge");

    fall_detect_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clock_fall |=> !clock_level ##1 !clock_fall)
        else $error("one falling edge seen twice");

    edge_to_shift_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clock_fall && !fifo_out_valid && !shift_hold |=> pop)
        else $error("falling edge did not reach the channels");

    lost_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clock_fall && !fifo_in_ready |=> sample_lost ##1 sample_lost)
        else $error("dropped edge not flagged");

    channel_split_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pop && pop_word.recirc_select[0] && !pop_word.recirc_select[2]
        |=> stage[0][0] == $past(data_out[0]) && stage[2][0] == $past(pop_word.data_in[2]))
        else $error("channels did not act independently");

endmodule : quad_shift_register

// File: src/shift_pkg.sv
package shift_pkg;

    localparam int CHANNEL_COUNT = 4;
    localparam int STAGE_COUNT = 80;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic shift_clock;
        logic [CHANNEL_COUNT-1:0] recirc_select;
        logic [CHANNEL_COUNT-1:0] data_in;
    } pin_sample_type;

    typedef struct packed {
        logic [CHANNEL_COUNT-1:0] recirc_select;
        logic [CHANNEL_COUNT-1:0] data_in;
    } shift_word_type;

    localparam int PIN_WIDTH = $bits(pin_sample_type);
    localparam int WORD_WIDTH = $bits(shift_word_type);
    localparam pin_sample_type PIN_RESET = '0;
    localparam logic [STAGE_COUNT-1:0] STAGE_RESET = '0;

endpackage : shift_pkg

// File: test/pin_driver.sv
`timescale 1ns/1ns

module pin_driver
    import shift_pkg::*;
(
    // Timing base
    input wire logic sys_clk,
    // Pins into the shift register
    output logic shift_clock,
    output logic [CHANNEL_COUNT-1:0] data_in,
    output logic [CHANNEL_COUNT-1:0] recirc_select
);
    initial begin
        shift_clock = 1'b0;
        data_in = '0;
        recirc_select = '0;
    end

    // Settle the pins with the clock high, then let the clock fall
    task automatic pulse(input shift_word_type word, input int high_len);
        @(negedge sys_clk);
        data_in = word.data_in;
        recirc_select = word.recirc_select;
        shift_clock = 1'b1;
        repeat (high_len) @(negedge sys_clk);
        shift_clock = 1'b0;
        repeat (4) @(negedge sys_clk);
        // Hold is over: stale levels must never look valid
        data_in = ~word.data_in;
        recirc_select = ~word.recirc_select;
    endtask : pulse
endmodule : pin_driver

// File: test/testbench.sv
`timescale 1ns/1ns

module testbench
    import shift_pkg::*;
;
    logic sys_clk;
    logic sys_rst;
    logic shift_hold;
    logic shift_clock;
    logic [CHANNEL_COUNT-1:0] data_in;
    logic [CHANNEL_COUNT-1:0] recirc_select;
    logic [CHANNEL_COUNT-1:0] data_out;
    logic sample_ready;
    logic sample_lost;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    bit chain[CHANNEL_COUNT][$];
    shift_word_type w;
    shift_word_type held[$];

    quad_shift_register quad_shift_register_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .shift_clock(shift_clock), .data_in(data_in), .recirc_select(recirc_select),
        .shift_hold(shift_hold), .data_out(data_out), .sample_ready(sample_ready),
        .sample_lost(sample_lost));

    pin_driver pin_driver_i (.sys_clk(sys_clk), .shift_clock(shift_clock),
        .data_in(data_in), .recirc_select(recirc_select));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic model_shift(input shift_word_type word);
        bit tail;
        for (int c = 0; c < CHANNEL_COUNT; c++) begin
            tail = chain[c][$];
            chain[c].push_front(word.recirc_select[c] ? tail : word.data_in[c]);
            void'(chain[c].pop_back());
        end
    endtask : model_shift

    task automatic check_out();
        logic [CHANNEL_COUNT-1:0] exp;
        for (int c = 0; c < CHANNEL_COUNT; c++) exp[c] = chain[c][$];
        check_count++;
        if (data_out !== exp) begin
            n_errors++;
            $display("[ERR] %0t data_out %h expected %h", $time, data_out, exp);
        end
    endtask : check_out

    task automatic check_flag(input logic actual, input logic exp);
        check_count++;
        if (actual !== exp) begin
            n_errors++;
            $display("[ERR] %0t status flag %b expected %b", $time, actual, exp);
        end
    endtask : check_flag

    task automatic shift_one(input shift_word_type word, input int high_len);
        pin_driver_i.pulse(word, high_len);
        @(negedge sys_clk);
        model_shift(word);
        check_out();
    endtask : shift_one

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        sys_rst = 1'b1;
        shift_hold = 1'b0;
        for (int c = 0; c < CHANNEL_COUNT; c++) repeat (STAGE_COUNT) chain[c].push_back(1'b0);
        void'($urandom(51));
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check_out();
        check_flag(sample_ready, 1'b1);
        // Load, then circulate, then mixed selects with slow clocks
        for (int s = 0; s < 3; s++) begin
            for (int n = 0; n < 90; n++) begin
                w = shift_word_type'(WORD_WIDTH'($urandom));
                if (s == 0) w.recirc_select = '0;
                if (s == 1) w.recirc_select = '1;
                shift_one(w, 5 + (s == 2 ? $urandom_range(7) : 0));
            end
        end
        repeat (200) @(negedge sys_clk);
        check_out();
        check_flag(sample_lost, 1'b0);
        // Stall the drain, fill the buffer, overflow once
        shift_hold = 1'b1;
        for (int n = 0; n < FIFO_DEPTH + 1; n++) begin
            w = shift_word_type'(WORD_WIDTH'($urandom));
            if (n < FIFO_DEPTH) held.push_back(w);
            pin_driver_i.pulse(w, 5);
            if (n == FIFO_DEPTH - 1) begin
                // Ready is a registered copy, one cycle behind the buffer
                @(negedge sys_clk);
                check_flag(sample_ready, 1'b0);
            end
        end
        check_out();
        check_flag(sample_lost, 1'b1);
        shift_hold = 1'b0;
        repeat (20) @(negedge sys_clk);
        foreach (held[i]) model_shift(held[i]);
        check_out();
        check_flag(sample_ready, 1'b1);
        check_flag(sample_lost, 1'b1);
        conclude();
    end
endmodule : testbench
